// ===== logic/sfw_defs.svh
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH

// Command opcodes
`define SFW_OP_PAGE_WRITE 8'h02
`define SFW_OP_ALLOW_WRITE 8'h06
`define SFW_OP_DENY_WRITE 8'h04
`define SFW_OP_BLOCK_WIPE_A 8'h20
`define SFW_OP_BLOCK_WIPE_B 8'hD8
`define SFW_OP_ARRAY_WIPE_A 8'hC7
`define SFW_OP_ARRAY_WIPE_B 8'h60
`define SFW_OP_SLEEP 8'hB9
`define SFW_OP_WAKE 8'hAB
`define SFW_OP_BYTE_MODE_ON 8'h55
`define SFW_OP_BYTE_MODE_OFF 8'h45

// Frame byte counts: opcode only, opcode plus address, first data byte
`define SFW_NB_OPCODE 3'h1
`define SFW_NB_ADDRESS 3'h4
`define SFW_NB_DATA 3'h5

// Page geometry
`define SFW_PAGE_BYTES 256
`define SFW_PAGE_AW 8

// Core clock rate and internal durations in microseconds
`define SFW_MCLK_MHZ 20
`define SFW_PAGE_WRITE_US 1500
`define SFW_BLOCK_WIPE_US 2000000
`define SFW_ARRAY_WIPE_US 64000000
`define SFW_SLEEP_ENTRY_US 3
`define SFW_WAKE_US 30

// Cycle counts derived from the durations (whole microseconds, so exact)
`define SFW_PAGE_WRITE_CYC (`SFW_PAGE_WRITE_US * `SFW_MCLK_MHZ)
`define SFW_BLOCK_WIPE_CYC (`SFW_BLOCK_WIPE_US * `SFW_MCLK_MHZ)
`define SFW_ARRAY_WIPE_CYC (`SFW_ARRAY_WIPE_US * `SFW_MCLK_MHZ)
`define SFW_SLEEP_ENTRY_CYC (`SFW_SLEEP_ENTRY_US * `SFW_MCLK_MHZ)
`define SFW_WAKE_CYC (`SFW_WAKE_US * `SFW_MCLK_MHZ)

`endif

// ===== logic/sfw_pkg.sv
package sfw_pkg;
   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      SFW_ST_IDLE = 5'b00001,
      SFW_ST_OPER = 5'b00010,
      SFW_ST_DOZE = 5'b00100,
      SFW_ST_ASLEEP = 5'b01000,
      SFW_ST_WAKE = 5'b10000
   } sfw_state_t;

   // Kind of array operation being walked
   typedef enum logic [1:0] {
      SFW_OP_NONE = 2'h0,
      SFW_OP_PROG = 2'h1,
      SFW_OP_ERASE = 2'h2
   } sfw_op_t;
endpackage

// ===== logic/sfw_sync.sv
// Two-flop level synchroniser
module sfw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic i_clk, // destination clock
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic [W-1:0] i_d, // level from the other domain
   output logic [W-1:0] o_q // synchronised level
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   // First stage feeds only the second
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_r <= INIT;
         hold_r <= INIT;
      end
      else
      begin
         meta_r <= i_d;
         hold_r <= meta_r;
      end
   end

   assign o_q = hold_r;
endmodule // sfw_sync

// ===== logic/sfw_timer.sv
// Down counter for internal operation durations
module sfw_timer (
   input wire logic i_clk, // core clock
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic i_start, // load pulse
   input wire logic [31:0] i_load, // cycles to run
   output logic o_expired // count has reached zero
);
   logic [31:0] cnt_r;

   // Load on start, else count towards zero
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         cnt_r <= 32'h0;
      else if (i_start)
         cnt_r <= i_load;
      else if (cnt_r != 32'h0)
         cnt_r <= cnt_r - 32'h1;
   end

   assign o_expired = (cnt_r == 32'h0);
endmodule // sfw_timer

// ===== logic/sfw_flash.sv
`include "sfw_defs.svh"

module sfw_flash #(
   parameter int AW = 20, // array address width
   parameter int SECT_AW = 16, // sector address width
   parameter bit BIG_SECT = 1'b0, // large-sector variant
   parameter logic [31:0] PAGE_WRITE_CYC = 32'(`SFW_PAGE_WRITE_CYC),
   parameter logic [31:0] BLOCK_WIPE_CYC = 32'(`SFW_BLOCK_WIPE_CYC),
   parameter logic [31:0] ARRAY_WIPE_CYC = 32'(`SFW_ARRAY_WIPE_CYC),
   parameter logic [31:0] SLEEP_ENTRY_CYC = 32'(`SFW_SLEEP_ENTRY_CYC),
   parameter logic [31:0] WAKE_CYC = 32'(`SFW_WAKE_CYC)
) (
   input wire logic i_mclk, // core clock
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic i_sck, // link clock from host
   input wire logic i_cs_n, // chip select, active low
   input wire logic i_mosi, // serial data in
   input wire logic [7:0] i_byte_lane, // byte-wide data in
   input wire logic [2:0] i_guard, // guard bits
   input wire logic [AW-1:0] i_peek_addr, // array inspection address
   output logic [7:0] o_peek_data, // array byte at peek address
   output logic o_wip, // write in progress
   output logic o_wel, // write enable latch bit
   output logic o_asleep, // in deep power-down
   output logic o_standby, // deselected and idle
   output logic o_byte_mode // byte-wide mode active
);
   localparam int PG = `SFW_PAGE_BYTES;
   localparam int PW = `SFW_PAGE_AW;

   // Link domain state
   logic [2:0] bcnt_r;
   logic [2:0] nb_r;
   logic [6:0] shift_r;
   logic mode_r;
   logic lrst_r;
   logic [7:0] opc_r;
   logic [23:0] addr_r;
   logic [PW-1:0] ptr_r;
   logic [8:0] dcnt_r;
   logic ovf_r;
   logic [2:0] frm_nb_r;
   logic aligned_r;
   logic seq_r;
   logic [7:0] pbuf [0:PG-1];
   logic [PG-1:0] pmask_r;
   logic busy_l;
   logic asleep_l;
   logic first_edge;
   logic mode_nxt;
   logic byte_done;
   logic [7:0] byte_val;
   logic [2:0] nb_nxt;

   // Core domain state
   sfw_pkg::sfw_state_t st_r;
   sfw_pkg::sfw_op_t kind_r;
   logic wel_r;
   logic standby_r;
   logic seq_seen_r;
   logic cs_s;
   logic cs_d_r;
   logic seq_s;
   logic [AW:0] walk_r;
   logic [AW:0] walk_len_r;
   logic [AW-1:0] base_r;
   logic [7:0] arr_mem [0:(1 << AW)-1];
   logic [7:0] peek_r;
   logic tmr_start;
   logic [31:0] tmr_load;
   logic tmr_exp;
   logic exec;
   logic go_prog;
   logic go_sect;
   logic go_bulk;
   logic go_doze;
   logic go_wake;
   logic wel_set;
   logic wel_clr;
   logic wr_en;
   logic wr_and;
   logic [AW-1:0] wr_addr;
   logic [7:0] wr_data;

   // Guarded region: nonzero guard g protects the top 1/2^(7-g) of the array; guard 0 protects nothing
   function automatic logic prot_f(input logic [2:0] g, input logic [AW-1:0] a);
      logic hit;
      hit = (g != 3'h0);
      for (int k = 0; k < 7; k++)
      begin
         if (k < 7 - int'(g))
            hit = hit & a[AW-1-k];
      end
      return hit;
   endfunction

   // Core-domain reset copy that clears link-domain mode
   always_ff @(posedge i_mclk)
   begin
      lrst_r <= ~i_rst_n;
   end

   // Core state seen by the link logic
   sfw_sync #(.W(2), .INIT(2'b00)) u_sync_link (
      .i_clk(i_sck),
      .i_rst_n(1'b1),
      .i_d({o_wip, o_asleep}),
      .o_q({busy_l, asleep_l})
   );

   // Link decode: mode change applied from the previous frame's record
   always_comb
   begin
      first_edge = (nb_r == 3'h0) && (bcnt_r == 3'h0);
      mode_nxt = mode_r;
      if (first_edge && aligned_r && (frm_nb_r == `SFW_NB_OPCODE) && !asleep_l)
      begin
         if (opc_r == `SFW_OP_BYTE_MODE_ON)
            mode_nxt = 1'b1;
         else if (opc_r == `SFW_OP_BYTE_MODE_OFF)
            mode_nxt = 1'b0;
      end
      byte_done = mode_nxt | (bcnt_r == 3'h7);
      byte_val = mode_nxt ? i_byte_lane : {shift_r, i_mosi};
      nb_nxt = nb_r;
      if (byte_done && (nb_r != `SFW_NB_DATA))
         nb_nxt = nb_r + 3'h1;
   end

   // Byte-wide mode flag, cleared by power cycle
   always_ff @(posedge i_sck or posedge lrst_r)
   begin
      if (lrst_r)
         mode_r <= 1'b0;
      else if (!i_cs_n)
         mode_r <= mode_nxt;
   end

   // Frame counters, cleared while deselected or in reset
   always_ff @(posedge i_sck or posedge i_cs_n or posedge lrst_r)
   begin
      if (i_cs_n || lrst_r)
      begin
         bcnt_r <= 3'h0;
         nb_r <= 3'h0;
         shift_r <= 7'h00;
      end
      else
      begin
         bcnt_r <= mode_nxt ? 3'h0 : bcnt_r + 3'h1;
         nb_r <= nb_nxt;
         shift_r <= byte_val[6:0];
      end
   end

   // Frame toggle, one flip per frame; a known start lets the core see the first frame
   always_ff @(posedge i_sck or posedge lrst_r)
   begin
      if (lrst_r)
         seq_r <= 1'b0;
      else if (first_edge)
         seq_r <= ~seq_r;
   end

   // Frame record, stable while deselected
   always_ff @(posedge i_sck)
   begin
      frm_nb_r <= nb_nxt;
      aligned_r <= byte_done;
      if (first_edge)
      begin
         dcnt_r <= 9'h000;
         ovf_r <= 1'b0;
      end
      if (byte_done)
      begin
         if (nb_r == 3'h0)
            opc_r <= byte_val;
         else if (nb_r < `SFW_NB_ADDRESS)
            addr_r <= {addr_r[15:0], byte_val};
         if (nb_r == 3'h3)
            ptr_r <= byte_val;
         else if ((nb_r >= `SFW_NB_ADDRESS) && !busy_l)
         begin
            ptr_r <= ptr_r + 8'h01;
            if (dcnt_r == 9'(PG))
               ovf_r <= 1'b1;
            else
               dcnt_r <= dcnt_r + 9'h001;
         end
      end
   end

   // Page buffer, wrapping within the page
   always_ff @(posedge i_sck)
   begin
      if (byte_done && (nb_r >= `SFW_NB_ADDRESS) && !busy_l)
         pbuf[ptr_r] <= byte_val;
   end

   // Which page positions received data in this frame
   always_ff @(posedge i_sck)
   begin
      if (first_edge)
         pmask_r <= '0;
      else if (byte_done && (nb_r >= `SFW_NB_ADDRESS) && !busy_l)
         pmask_r[ptr_r] <= 1'b1;
   end

   // Select and frame toggle into the core domain
   sfw_sync #(.W(2), .INIT(2'b10)) u_sync_core (
      .i_clk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_d({i_cs_n, seq_r}),
      .o_q({cs_s, seq_s})
   );

   // Byte-wide flag reported in the core domain
   sfw_sync #(.W(1), .INIT(1'b0)) u_sync_mode (
      .i_clk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_d(mode_r),
      .o_q(o_byte_mode)
   );

   // Select rise detect and frame bookkeeping
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         cs_d_r <= 1'b1;
         seq_seen_r <= 1'b0;
      end
      else
      begin
         cs_d_r <= cs_s;
         if (exec)
            seq_seen_r <= seq_s;
      end
   end

   // Command decode at select rise
   always_comb
   begin
      exec = cs_s && !cs_d_r && (seq_s != seq_seen_r);
      go_prog = 1'b0;
      go_sect = 1'b0;
      go_bulk = 1'b0;
      go_doze = 1'b0;
      go_wake = 1'b0;
      wel_set = 1'b0;
      wel_clr = 1'b0;
      if (exec && aligned_r)
      begin
         if (st_r == sfw_pkg::SFW_ST_ASLEEP || st_r == sfw_pkg::SFW_ST_DOZE)
            go_wake = (opc_r == `SFW_OP_WAKE);
         else if (st_r == sfw_pkg::SFW_ST_IDLE)
         begin
            if (frm_nb_r == `SFW_NB_OPCODE)
            begin
               wel_set = (opc_r == `SFW_OP_ALLOW_WRITE);
               wel_clr = (opc_r == `SFW_OP_DENY_WRITE);
               go_doze = (opc_r == `SFW_OP_SLEEP);
               go_bulk = wel_r && (i_guard == 3'h0) &&
                  ((opc_r == `SFW_OP_ARRAY_WIPE_A) ||
                   ((opc_r == `SFW_OP_ARRAY_WIPE_B) && !BIG_SECT));
            end
            if (frm_nb_r == `SFW_NB_ADDRESS)
               go_sect = wel_r && !prot_f(i_guard, addr_r[AW-1:0]) &&
                  ((opc_r == `SFW_OP_BLOCK_WIPE_A) || (opc_r == `SFW_OP_BLOCK_WIPE_B));
            if (frm_nb_r == `SFW_NB_DATA)
               go_prog = wel_r && !prot_f(i_guard, addr_r[AW-1:0]) &&
                  (opc_r == `SFW_OP_PAGE_WRITE);
         end
      end
      tmr_start = go_prog | go_sect | go_bulk | go_doze | go_wake;
      tmr_load = WAKE_CYC;
      if (go_prog)
         tmr_load = PAGE_WRITE_CYC;
      else if (go_sect)
         tmr_load = BLOCK_WIPE_CYC;
      else if (go_bulk)
         tmr_load = ARRAY_WIPE_CYC;
      else if (go_doze)
         tmr_load = SLEEP_ENTRY_CYC;
   end

   // Shared duration timer
   sfw_timer u_timer (
      .i_clk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(tmr_start),
      .i_load(tmr_load),
      .o_expired(tmr_exp)
   );

   // Sequencer
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         st_r <= sfw_pkg::SFW_ST_IDLE;
      else
      begin
         case (st_r)
            sfw_pkg::SFW_ST_IDLE:
            begin
               if (go_prog | go_sect | go_bulk)
                  st_r <= sfw_pkg::SFW_ST_OPER;
               else if (go_doze)
                  st_r <= sfw_pkg::SFW_ST_DOZE;
            end
            sfw_pkg::SFW_ST_OPER:
            begin
               if ((walk_r == walk_len_r) && tmr_exp)
                  st_r <= sfw_pkg::SFW_ST_IDLE;
            end
            sfw_pkg::SFW_ST_DOZE:
            begin
               if (go_wake)
                  st_r <= sfw_pkg::SFW_ST_WAKE;
               else if (tmr_exp)
                  st_r <= sfw_pkg::SFW_ST_ASLEEP;
            end
            sfw_pkg::SFW_ST_ASLEEP:
            begin
               if (go_wake)
                  st_r <= sfw_pkg::SFW_ST_WAKE;
            end
            sfw_pkg::SFW_ST_WAKE:
            begin
               if (tmr_exp && !tmr_start)
                  st_r <= sfw_pkg::SFW_ST_IDLE;
            end
            default:
               st_r <= sfw_pkg::SFW_ST_IDLE;
         endcase
      end
   end

   // Write enable latch
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         wel_r <= 1'b0;
      else if (wel_clr || go_prog || go_sect || go_bulk)
         wel_r <= 1'b0;
      else if (wel_set)
         wel_r <= 1'b1;
   end

   // Operation walk setup and progress
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         kind_r <= sfw_pkg::SFW_OP_NONE;
         walk_r <= '0;
         walk_len_r <= '0;
         base_r <= '0;
      end
      else if (go_prog)
      begin
         kind_r <= sfw_pkg::SFW_OP_PROG;
         walk_r <= '0;
         walk_len_r <= (AW+1)'(PG);
         base_r <= {addr_r[AW-1:PW], {PW{1'b0}}};
      end
      else if (go_sect)
      begin
         kind_r <= sfw_pkg::SFW_OP_ERASE;
         walk_r <= '0;
         walk_len_r <= (AW+1)'(1) << SECT_AW;
         base_r <= {addr_r[AW-1:SECT_AW], {SECT_AW{1'b0}}};
      end
      else if (go_bulk)
      begin
         kind_r <= sfw_pkg::SFW_OP_ERASE;
         walk_r <= '0;
         walk_len_r <= (AW+1)'(1) << AW;
         base_r <= '0;
      end
      else if ((st_r == sfw_pkg::SFW_ST_OPER) && (walk_r != walk_len_r))
         walk_r <= walk_r + (AW+1)'(1);
   end

   // Array write request for the current walk step
   always_comb
   begin
      logic [PW-1:0] src;
      src = ptr_r + walk_r[PW-1:0];
      if (!ovf_r)
         src = walk_r[PW-1:0];
      wr_en = (st_r == sfw_pkg::SFW_ST_OPER) && (walk_r != walk_len_r);
      wr_and = (kind_r == sfw_pkg::SFW_OP_PROG);
      wr_addr = base_r + walk_r[AW-1:0];
      wr_data = 8'hFF;
      if (wr_and)
      begin
         wr_en = wr_en && (ovf_r || pmask_r[walk_r[PW-1:0]]);
         wr_data = pbuf[src];
      end
   end

   // Array storage
   always_ff @(posedge i_mclk)
   begin
      if (wr_en)
      begin
         if (wr_and)
            arr_mem[wr_addr] <= arr_mem[wr_addr] & wr_data;
         else
            arr_mem[wr_addr] <= wr_data;
      end
      peek_r <= arr_mem[i_peek_addr];
   end

   // Standby indication
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         standby_r <= 1'b1;
      else
         standby_r <= cs_s && (st_r == sfw_pkg::SFW_ST_IDLE) && !tmr_start;
   end

   // Outputs
   assign o_wip = st_r[1];
   assign o_asleep = st_r[3];
   assign o_wel = wel_r;
   assign o_standby = standby_r;
   assign o_peek_data = peek_r;
endmodule // sfw_flash

// ===== verification/sfw_flash_asserts.sv
module sfw_flash_chk (
   input wire logic i_mclk, // core clock
   input wire logic i_rst_n, // reset, active low
   input wire logic i_cs_n, // chip select
   input wire logic o_wip, // busy flag
   input wire logic o_wel, // write latch
   input wire logic o_asleep, // power-down
   input wire logic o_standby // standby
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   localparam int MIN_BUSY = 256;
   localparam int MAX_BUSY = 4110;
   logic [12:0] busy_r;
   // Length of the current busy stretch
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n || !o_wip)
         busy_r <= 13'h0;
      else
         busy_r <= busy_r + 13'h1;
   end
   sequence busy_run;
      o_wip [*8];
   endsequence
   wip_wel_a: assert property ($rose(o_wip) |-> !o_wel)
      else $error("latch still set at start");
   wip_cause_a: assert property ($rose(o_wip) |-> $past(o_wel))
      else $error("operation without latch");
   wip_hold_a: assert property ($rose(o_wip) |=> busy_run)
      else $error("busy dropped early");
   busy_min_a: assert property ($fell(o_wip) |-> busy_r >= MIN_BUSY)
      else $error("busy too short");
   busy_max_a: assert property (busy_r <= MAX_BUSY)
      else $error("busy too long");
   wel_cause_a: assert property ($changed(o_wel) |-> $past(i_cs_n, 2))
      else $error("latch moved inside a frame");
   sleep_idle_a: assert property (o_asleep |-> !o_wip)
      else $error("busy while asleep");
   standby_off_a: assert property ((o_wip || o_asleep) && $past(o_wip || o_asleep)
      |-> !o_standby)
      else $error("standby while active");
endmodule // sfw_flash_chk

// ===== verification/sfw_host.sv
`include "sfw_defs.svh"
module sfw_host (
   output logic o_sck, // link clock
   output logic o_cs_n, // chip select
   output logic o_mosi, // serial data
   output logic [7:0] o_byte_lane // byte lane
);
   timeunit 1ns;
   timeprecision 100ps;
   logic bm = 1'b0; // host view of byte mode
   // Idle link: clock still, select high
   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      o_byte_lane = 8'h00;
   end
   // One link clock, data sampled on the rise
   task automatic pulse(input realtime half = 7.5);
      #half o_sck = 1'b1;
      #half o_sck = 1'b0;
   endtask
   // Whole frame, then optional stray bits
   task automatic send(input logic [7:0] q[$], input int tail = 0);
      o_cs_n = 1'b0;
      #20;
      foreach (q[i])
      begin
         if (bm)
         begin
            o_byte_lane = q[i];
            pulse(50.0);
         end
         else
            for (int n = 7; n >= 0; n--)
            begin
               o_mosi = q[i][n];
               pulse();
            end
      end
      repeat (tail)
      begin
         o_mosi = 1'b1;
         pulse();
      end
      #10 o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      o_byte_lane = ~o_byte_lane;
      if (q.size() == 1 && q[0] == `SFW_OP_BYTE_MODE_ON)
         bm = 1'b1;
      if (q.size() == 1 && q[0] == `SFW_OP_BYTE_MODE_OFF)
         bm = 1'b0;
      #300;
   endtask
endmodule // sfw_host

// ===== verification/sfw_flash_test.sv
`include "sfw_defs.svh"
module sfw_flash_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] i_guard = 3'h0;
   logic [11:0] i_peek_addr = 12'h000;
   logic sck, cs_n, mosi;
   logic [7:0] lane, o_peek_data;
   logic o_wip, o_wel, o_asleep, o_standby, o_byte_mode;
   int errors = 0;
   int checks = 0;
   // Core clock, 50 ns
   always #25 i_mclk = ~i_mclk;
   sfw_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .o_byte_lane(lane));
   // Sleep entry and wake run at their default counts, 60 and 600 cycles
   sfw_flash #(.AW(12), .SECT_AW(8), .PAGE_WRITE_CYC(32'h12C), .BLOCK_WIPE_CYC(32'h10A),
      .ARRAY_WIPE_CYC(32'h100A)) u_dut (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
      .i_byte_lane(lane), .i_guard(i_guard), .i_peek_addr(i_peek_addr),
      .o_peek_data(o_peek_data), .o_wip(o_wip), .o_wel(o_wel), .o_asleep(o_asleep),
      .o_standby(o_standby), .o_byte_mode(o_byte_mode));
   // Step past clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #2;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk_flag(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] b[$], input int tail = 0);
      u_host.send(b, tail);
      tick(6);
   endtask
   // Bounded wait for the array operation to end
   task automatic settle();
      for (int n = 0; n < 6000 && o_wip !== 1'b0; n++)
         tick(1);
      if (o_wip !== 1'b0)
      begin
         errors++;
         close_out();
      end
   endtask
   task automatic peek(input logic [11:0] a, input logic [7:0] exp);
      i_peek_addr = a;
      tick(2);
      chk_byte("array byte", exp, o_peek_data);
   endtask
   // Main sequence
   initial
   begin
      logic [7:0] q[$];
      tick(16);
      i_rst_n = 1'b1;
      tick(4);
      chk_flag("standby", 1'b1, o_standby);
      for (int k = 0; k < 2; k++)
      begin
         cmd('{`SFW_OP_ALLOW_WRITE});
         cmd('{k ? `SFW_OP_ARRAY_WIPE_B : `SFW_OP_ARRAY_WIPE_A});
         chk_flag("wip", 1'b1, o_wip);
         chk_flag("wel", 1'b0, o_wel);
         chk_flag("standby", 1'b0, o_standby);
         settle();
         peek(12'hFFF, 8'hFF);
      end
      $display("array wipe done");
      cmd('{`SFW_OP_ALLOW_WRITE});
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h01, 8'h10, 8'hA5, 8'h3C});
      settle();
      peek(12'h110, 8'hA5);
      peek(12'h111, 8'h3C);
      peek(12'h112, 8'hFF);
      cmd('{`SFW_OP_ALLOW_WRITE});
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h01, 8'h10, 8'h0F});
      settle();
      peek(12'h110, 8'h05);
      q = '{`SFW_OP_PAGE_WRITE, 8'h00, 8'h02, 8'h10};
      for (int k = 0; k < 258; k++)
         q.push_back(8'(k));
      cmd('{`SFW_OP_ALLOW_WRITE});
      cmd(q);
      settle();
      peek(12'h200, 8'h02);
      peek(12'h2FF, 8'h01);
      $display("page write done");
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h03, 8'h00, 8'h00});
      chk_flag("wip", 1'b0, o_wip);
      cmd('{`SFW_OP_ALLOW_WRITE});
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h03, 8'h00, 8'h00}, 3);
      chk_flag("wip", 1'b0, o_wip);
      i_guard = 3'h7;
      cmd('{`SFW_OP_BLOCK_WIPE_A, 8'h00, 8'h03, 8'h00});
      chk_flag("wip", 1'b0, o_wip);
      cmd('{`SFW_OP_ARRAY_WIPE_A});
      chk_flag("wip", 1'b0, o_wip);
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h0F, 8'h00, 8'h00});
      chk_flag("wip", 1'b0, o_wip);
      chk_flag("wel", 1'b1, o_wel);
      i_guard = 3'h0;
      peek(12'hF00, 8'hFF);
      $display("refusals done");
      cmd('{`SFW_OP_BLOCK_WIPE_A, 8'h00, 8'h01, 8'hAB});
      chk_flag("wip", 1'b1, o_wip);
      settle();
      peek(12'h110, 8'hFF);
      cmd('{`SFW_OP_ALLOW_WRITE});
      cmd('{`SFW_OP_BLOCK_WIPE_B, 8'h00, 8'h02, 8'hFF});
      cmd('{`SFW_OP_SLEEP});
      settle();
      peek(12'h200, 8'hFF);
      tick(40);
      chk_flag("asleep", 1'b0, o_asleep);
      $display("sector wipe done");
      cmd('{`SFW_OP_SLEEP});
      chk_flag("asleep", 1'b0, o_asleep);
      tick(80);
      chk_flag("asleep", 1'b1, o_asleep);
      cmd('{`SFW_OP_ALLOW_WRITE});
      chk_flag("wel", 1'b0, o_wel);
      cmd('{`SFW_OP_WAKE});
      tick(620);
      chk_flag("asleep", 1'b0, o_asleep);
      cmd('{`SFW_OP_ALLOW_WRITE});
      chk_flag("wel", 1'b1, o_wel);
      cmd('{`SFW_OP_DENY_WRITE});
      chk_flag("wel", 1'b0, o_wel);
      $display("power-down done");
      cmd('{`SFW_OP_BYTE_MODE_ON});
      cmd('{`SFW_OP_ALLOW_WRITE});
      chk_flag("byte mode", 1'b1, o_byte_mode);
      cmd('{`SFW_OP_PAGE_WRITE, 8'h00, 8'h04, 8'h00, 8'h96});
      settle();
      peek(12'h400, 8'h96);
      cmd('{`SFW_OP_BYTE_MODE_OFF});
      cmd('{`SFW_OP_ALLOW_WRITE});
      chk_flag("byte mode", 1'b0, o_byte_mode);
      chk_flag("wel", 1'b1, o_wel);
      $display("byte mode done");
      close_out();
   end
endmodule // sfw_flash_test
bind sfw_flash sfw_flash_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
   .o_wip(o_wip), .o_wel(o_wel), .o_asleep(o_asleep), .o_standby(o_standby));
